// ---- verification/mbc_master_model.sv ----
`default_nettype none
// Far-side stand-in: the framing engine behind the bus, one event pulse per request
module mbc_master_model (
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic [2:0] sel,
	output logic      [7:0] ev = 8'h00
);
	// Registered so every event lasts exactly one cycle, as the block expects
	always_ff @(posedge mclk) begin
		ev <= go ? (8'h01 << sel) : 8'h00;
	end
endmodule : mbc_master_model
`default_nettype wire

// ---- verification/mbc_port_cfg_asserts.sv ----
`default_nettype none
module mbc_port_cfg_chk (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        ev_good,
	input wire logic        bus_fault,
	input wire logic        irq,
	input wire logic [7:0]  bus_slave_address,
	input wire logic [1:0]  bus_parity_select,
	input wire logic [15:0] proc_time_cycles_ms,
	input wire logic [15:0] dead_time_ms
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Handshake steps of the two transfers
	sequence s_wtaken; s_axi_awvalid && s_axi_awready; endsequence
	sequence s_rtaken; s_axi_arvalid && s_axi_arready; endsequence
	a_write_answer: assert property (s_wtaken |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_rtaken |=> s_axi_rvalid) else $error("read not answered");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_parity_legal: assert property (bus_parity_select != 2'h3) else $error("parity code 3");
	a_good_clears: assert property (ev_good |=> !bus_fault) else $error("fault after good telegram");
	// Checked during reset too, so the default disable is overridden
	a_reset_values: assert property (disable iff (1'b0) rst |=> bus_slave_address == 8'h01
		&& bus_parity_select == 2'h2 && proc_time_cycles_ms == 16'h03E8 && dead_time_ms == 16'h0000
		&& !irq && !bus_fault) else $error("bad reset values");
endmodule : mbc_port_cfg_chk
bind mbc_port_cfg mbc_port_cfg_chk u_chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ev_good,
	.bus_fault, .irq, .bus_slave_address, .bus_parity_select, .proc_time_cycles_ms, .dead_time_ms);
`default_nettype wire

// ---- verification/tb_modbus_rtu_slave_port_config.sv ----
`default_nettype none
module tb_modbus_rtu_slave_port_config;
	timeunit 1ns;
	timeprecision 1ps;
	import mbc_pkg::*;
	logic        mclk = 0, rst = 1, go = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, addr_switch = 0, ev, bus_slave_address;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rtu_enable, bus_fault, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bus_parity_select, rr, br;
	logic [2:0]  sel = 0;
	logic [23:0] baud_divisor;
	logic [15:0] proc_time_cycles_ms, dead_time_ms;
	int          num_errors = 0, checks_done = 0, i, j;
	int          rates [9] = '{4800, 9600, 19200, 38400, 57600, 76800, 93750, 115200, 187500};
	always #20 mclk = ~mclk;
	mbc_port_cfg DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addr_switch,
		.ev_good(ev[0]), .ev_reject(ev[1]), .ev_framing(ev[2]), .ev_overrun(ev[3]), .ev_parity(ev[4]),
		.ev_start(ev[5]), .ev_checksum(ev[6]), .ev_length(ev[7]), .rtu_enable, .bus_slave_address,
		.bus_parity_select, .baud_divisor, .proc_time_cycles_ms, .dead_time_ms, .bus_fault, .irq);
	mbc_master_model u_far (.mclk, .go, .sel, .ev);
	task results;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// A wait that runs out ends the run at once
	task tmo(input int n);
		if (n >= 60) begin
			num_errors++;
			$display("ERROR %0t no bus answer", $time);
			results();
		end
	endtask : tmo
	// Address and data offered together; bready held so the answer edge ends the task
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid && n < 60);
		br = s_axi_bresp;
		s_axi_bready <= 0;
		tmo(n);
	endtask : wr
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid && n < 60);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		tmo(n);
	endtask : rd
	task rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask : rdc
	task pulse(input logic [2:0] s);
		@(posedge mclk);
		go <= 1;
		sel <= s;
		@(posedge mclk);
		go <= 0;
	endtask : pulse
	// Main sequence; a switch change gets a few cycles to pass its synchroniser
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 0;
		rdc(OFS_PROTOCOL, 0);
		rdc(OFS_BAUD, 7);
		rdc(OFS_DIVISOR, CLK_HZ / 19200);
		rdc(OFS_ADDR_USE, 1);
		rdc(OFS_PARITY, 2);
		rdc(OFS_PROC_MS, 1000);
		rdc(OFS_DEAD_MS, 0);
		rdc(OFS_MON_MS, 100);
		for (i = 1; i >= 0; i--) begin
			wr(OFS_PROTOCOL, i + 1);
			rdc(OFS_PROTOCOL, i + 1);
			chk(rtu_enable, i);
		end
		for (i = 0; i < 9; i++) begin
			wr(OFS_BAUD, i + 5);
			rdc(OFS_DIVISOR, CLK_HZ / rates[i]);
		end
		wr(OFS_BAUD, 4);
		wr(OFS_BAUD, 14);
		rdc(OFS_BAUD, 13);
		chk(baud_divisor, CLK_HZ / 187500);
		for (i = 0; i < 4; i++) begin
			wr(OFS_PARITY, i);
			rd(OFS_PARITY);
			chk(bus_parity_select, (i == 3) ? 2 : i);
		end
		wr(OFS_ADDR, 247);
		wr(OFS_ADDR, 248);
		wr(OFS_ADDR, 0);
		rdc(OFS_ADDR, 247);
		rdc(OFS_ADDR_USE, 1);
		chk(bus_slave_address, 1);
		for (i = 0; i < 3; i++) begin
			addr_switch <= (i == 1) ? 8'h05 : 8'h00;
			repeat (4) @(posedge mclk);
			wr(OFS_RESTART, 1);
			rdc(OFS_ADDR_USE, (i == 1) ? 5 : 247);
		end
		wr(OFS_PROC_MS, 500);
		wr(OFS_DEAD_MS, 3);
		rdc(OFS_DEAD_MS, 3);
		chk(proc_time_cycles_ms, 500);
		chk(dead_time_ms, 3);
		for (i = 0; i < 8; i++) for (j = 0; j <= i; j++) pulse(3'(i));
		for (i = 0; i < 8; i++) rdc(8'(OFS_STAT0 + 4 * i), i + 1);
		rdc(OFS_STATUS, 6);
		chk(irq, 0);
		wr(OFS_MASK, 4);
		rdc(OFS_MASK, 4);
		chk(irq, 1);
		wr(OFS_STATUS, 4);
		rdc(OFS_STATUS, 2);
		chk(irq, 0);
		wr(OFS_MASK, 0);
		wr(OFS_MON_MS, 1);
		wr(OFS_PROTOCOL, 2);
		repeat (CYC_PER_MS + 100) @(posedge mclk);
		chk(bus_fault, 1);
		rdc(OFS_STATUS, 3);
		pulse(0);
		repeat (2) @(posedge mclk);
		chk(bus_fault, 0);
		wr(OFS_MON_MS, 0);
		repeat (CYC_PER_MS * 2) @(posedge mclk);
		chk(bus_fault, 0);
		rd(8'h30);
		chk(rr, 2);
		chk(rv, 0);
		wr(8'h30, 1);
		chk(br, 2);
		results();
	end
endmodule : tb_modbus_rtu_slave_port_config
`default_nettype wire

// ---- verilog/mbc_counter.sv ----
`default_nettype none
// Saturating event counter, one per statistics slot
module mbc_counter #(
	parameter int W = 16
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         inc,
	output logic [W-1:0]      count
);
	initial begin
		if (W < 2 || W > 32) $error("mbc_counter width out of range");
	end
	// Saturate rather than wrap, so a busy bus never looks quiet
	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= '0;
		end else if (inc && count != {W{1'b1}}) begin
			count <= count + 1'b1;
		end
	end
endmodule : mbc_counter
`default_nettype wire

// ---- verilog/mbc_pkg.sv ----
`default_nettype none
package mbc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_PROTOCOL = 8'h00;
	localparam logic [7:0] OFS_BAUD     = 8'h04;
	localparam logic [7:0] OFS_ADDR     = 8'h08;
	localparam logic [7:0] OFS_ADDR_USE = 8'h0C;
	localparam logic [7:0] OFS_PARITY   = 8'h10;
	localparam logic [7:0] OFS_PROC_MS  = 8'h14;
	localparam logic [7:0] OFS_DEAD_MS  = 8'h18;
	localparam logic [7:0] OFS_MON_MS   = 8'h1C;
	localparam logic [7:0] OFS_STATUS   = 8'h20;
	localparam logic [7:0] OFS_MASK     = 8'h24;
	localparam logic [7:0] OFS_RESTART  = 8'h28;
	localparam logic [7:0] OFS_DIVISOR  = 8'h2C;
	localparam logic [7:0] OFS_STAT0    = 8'h40;
	// Reset values, protocol and parity codes, and legal ranges
	localparam logic [7:0]  RST_PROTOCOL = 8'h00;
	localparam logic [7:0]  PROTO_RTU    = 8'h02;
	localparam logic [7:0]  RST_BAUD     = 8'h07;
	localparam logic [7:0]  BAUD_MIN     = 8'h05;
	localparam logic [7:0]  BAUD_MAX     = 8'h0D;
	localparam logic [7:0]  RST_ADDR     = 8'h01;
	localparam logic [7:0]  ADDR_MIN     = 8'h01;
	localparam logic [7:0]  ADDR_MAX     = 8'hF7;
	localparam logic [1:0]  PAR_NONE     = 2'h0;
	localparam logic [1:0]  PAR_ODD      = 2'h1;
	localparam logic [1:0]  PAR_EVEN     = 2'h2;
	localparam logic [1:0]  RST_PARITY   = PAR_EVEN;
	localparam logic [15:0] RST_PROC_MS  = 16'h03E8;
	localparam logic [15:0] RST_DEAD_MS  = 16'h0000;
	localparam logic [15:0] RST_MON_MS   = 16'h0064;
	// Timing
	localparam int CLK_HZ        = 25000000;
	localparam int MS_TIME_US    = 1000;
	localparam int CYC_PER_MS    = CLK_HZ / 1000000 * MS_TIME_US;
	// Number of statistics counters
	localparam int NUM_STATS     = 8;
	// Status bits
	localparam int ST_FAULT = 0;
	localparam int ST_ERR   = 1;
	localparam int ST_GOOD  = 2;
	localparam int ST_W     = 3;
endpackage : mbc_pkg
`default_nettype wire

// ---- verilog/mbc_port_cfg.sv ----
// Added by the designer: the AXI4-Lite slave port and the address map.
`default_nettype none
module mbc_port_cfg #(
	parameter int STAT_W = 16
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Hardware address switch pins
	input  wire logic [7:0]           addr_switch,
	// Telegram events from the framing logic, one-cycle pulses
	input  wire logic                 ev_good,
	input  wire logic                 ev_reject,
	input  wire logic                 ev_framing,
	input  wire logic                 ev_overrun,
	input  wire logic                 ev_parity,
	input  wire logic                 ev_start,
	input  wire logic                 ev_checksum,
	input  wire logic                 ev_length,
	// Settings out to the serial engine
	output logic                      rtu_enable,
	output logic [7:0]                bus_slave_address,
	output logic [1:0]                bus_parity_select,
	output logic [23:0]               baud_divisor,
	output logic [15:0]               proc_time_cycles_ms,
	output logic [15:0]               dead_time_ms,
	output logic                      bus_fault,
	output logic                      irq
);
	import mbc_pkg::*;
	if (STAT_W < 2 || STAT_W > 32) $error("STAT_W out of range");
	logic [7:0]  bus_protocol_select;
	logic [7:0]  bus_baud_code;
	logic [7:0]  sw_addr;
	logic [15:0] proc_ms;
	logic [15:0] dead_ms;
	logic [15:0] bus_monitor_time;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	logic        restart_req;
	logic [7:0]  sw_meta;
	logic [7:0]  sw_sync;
	// Two-stage synchroniser for the switch pins; kept running through reset so the
	// address latched at reset release already reflects the switch
	always_ff @(posedge mclk) begin
		sw_meta <= addr_switch;
		sw_sync <= sw_meta;
	end
	// Write channel: accept address and data in either order
	logic       aw_hold;
	logic       w_hold;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire        wr_go = aw_hold && w_hold && !s_axi_bvalid;
	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_hold       <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr       <= 8'h00;
		end else begin
			s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			w_hold       <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
		end else begin
			s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wready && s_axi_wvalid) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold <= 1'b0;
			end
		end
	end
	// Write response; unmapped addresses answer SLVERR
	logic wr_hit;
	always_comb begin
		unique case (aw_addr)
			OFS_PROTOCOL, OFS_BAUD, OFS_ADDR, OFS_PARITY, OFS_PROC_MS, OFS_DEAD_MS,
			OFS_MON_MS, OFS_STATUS, OFS_MASK, OFS_RESTART: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// Configuration registers; out-of-range codes are ignored
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_protocol_select <= RST_PROTOCOL;
			bus_baud_code       <= RST_BAUD;
			sw_addr             <= RST_ADDR;
			bus_parity_select   <= RST_PARITY;
			proc_ms             <= RST_PROC_MS;
			dead_ms             <= RST_DEAD_MS;
			bus_monitor_time    <= RST_MON_MS;
			mask                <= '0;
			restart_req         <= 1'b0;
		end else begin
			restart_req <= 1'b0;
			if (wr_go && w_strb[0]) begin
				unique case (aw_addr)
					OFS_PROTOCOL: bus_protocol_select <= w_data[7:0];
					OFS_BAUD: begin
						if (w_data[7:0] >= BAUD_MIN && w_data[7:0] <= BAUD_MAX) begin
							bus_baud_code <= w_data[7:0];
						end
					end
					OFS_ADDR: begin
						if (w_data[7:0] >= ADDR_MIN && w_data[7:0] <= ADDR_MAX) begin
							sw_addr <= w_data[7:0];
						end
					end
					OFS_PARITY: begin
						if (w_data[1:0] != 2'h3) begin
							bus_parity_select <= w_data[1:0];
						end
					end
					OFS_MASK:    mask        <= w_data[ST_W-1:0];
					OFS_RESTART: restart_req <= w_data[0];
					default: ;
				endcase
			end
			if (wr_go && w_strb[0] && w_strb[1]) begin
				unique case (aw_addr)
					OFS_PROC_MS: proc_ms          <= w_data[15:0];
					OFS_DEAD_MS: dead_ms          <= w_data[15:0];
					OFS_MON_MS:  bus_monitor_time <= w_data[15:0];
					default: ;
				endcase
			end
		end
	end
	// Effective address latched at reset release and on restart only
	logic addr_load;
	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_load         <= 1'b1;
			bus_slave_address <= RST_ADDR;
		end else begin
			addr_load <= 1'b0;
			if (addr_load || restart_req) begin
				bus_slave_address <= (sw_sync == 8'h00) ? sw_addr : sw_sync;
			end
		end
	end
	// Baud divisor table; every entry folds to a constant, so no divider is built
	function automatic logic [23:0] baud_div(input logic [7:0] code);
		unique case (code)
			8'h05:   baud_div = 24'(CLK_HZ / 4800);
			8'h06:   baud_div = 24'(CLK_HZ / 9600);
			8'h07:   baud_div = 24'(CLK_HZ / 19200);
			8'h08:   baud_div = 24'(CLK_HZ / 38400);
			8'h09:   baud_div = 24'(CLK_HZ / 57600);
			8'h0A:   baud_div = 24'(CLK_HZ / 76800);
			8'h0B:   baud_div = 24'(CLK_HZ / 93750);
			8'h0C:   baud_div = 24'(CLK_HZ / 115200);
			8'h0D:   baud_div = 24'(CLK_HZ / 187500);
			default: baud_div = 24'(CLK_HZ / 19200);
		endcase
	endfunction : baud_div
	// Registered settings outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			rtu_enable          <= 1'b0;
			baud_divisor        <= 24'h000000;
			proc_time_cycles_ms <= RST_PROC_MS;
			dead_time_ms        <= RST_DEAD_MS;
		end else begin
			rtu_enable          <= (bus_protocol_select == PROTO_RTU);
			baud_divisor        <= baud_div(bus_baud_code);
			proc_time_cycles_ms <= proc_ms;
			dead_time_ms        <= dead_ms;
		end
	end
	// Millisecond tick enable
	logic [15:0] ms_div;
	logic        ms_tick;
	always_ff @(posedge mclk) begin
		if (rst) begin
			ms_div  <= 16'h0000;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (ms_div == 16'(CYC_PER_MS - 1));
			ms_div  <= (ms_div == 16'(CYC_PER_MS - 1)) ? 16'h0000 : ms_div + 16'h0001;
		end
	end
	// Bus-loss watchdog, restarted by every good telegram; a good telegram beats a same-cycle expiry
	logic [15:0] mon_ms;
	logic        mon_expire;
	always_ff @(posedge mclk) begin
		if (rst) begin
			mon_ms     <= 16'h0000;
			mon_expire <= 1'b0;
			bus_fault  <= 1'b0;
		end else begin
			mon_expire <= 1'b0;
			if (bus_monitor_time == 16'h0000 || !rtu_enable || ev_good) begin
				mon_ms    <= 16'h0000;
				bus_fault <= 1'b0;
			end else if (ms_tick && !bus_fault) begin
				mon_ms <= mon_ms + 16'h0001;
				if (mon_ms + 16'h0001 >= bus_monitor_time) begin
					bus_fault  <= 1'b1;
					mon_expire <= 1'b1;
				end
			end
		end
	end
	// Statistics counters
	logic [NUM_STATS-1:0]  ev_vec;
	logic [STAT_W-1:0]     stat [NUM_STATS];
	assign ev_vec = {ev_length, ev_checksum, ev_start, ev_parity, ev_overrun, ev_framing, ev_reject, ev_good};
	// slots follow the index order of ev_vec
	for (genvar i = 0; i < NUM_STATS; i++) begin : g_stat
		mbc_counter #(.W(STAT_W)) u_cnt (
			.mclk  (mclk),
			.rst   (rst),
			.inc   (ev_vec[i]),
			.count (stat[i])
		);
	end
	// Sticky status; a new event beats a same-cycle clear
	logic [ST_W-1:0] st_set;
	logic [ST_W-1:0] st_clr;
	assign st_set = {ev_good, |ev_vec[NUM_STATS-1:1], mon_expire};
	assign st_clr = (wr_go && w_strb[0] && aw_addr == OFS_STATUS) ? w_data[ST_W-1:0] : '0;
	always_ff @(posedge mclk) begin
		if (rst) begin
			status <= '0;
			irq    <= 1'b0;
		end else begin
			status <= (status & ~st_clr) | st_set;
			irq    <= |(((status & ~st_clr) | st_set) & mask);
		end
	end
	// Read channel, one cycle to answer
	logic [31:0] rd_val;
	logic        rd_hit;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_PROTOCOL: rd_val = {24'h000000, bus_protocol_select};
			OFS_BAUD:     rd_val = {24'h000000, bus_baud_code};
			OFS_ADDR:     rd_val = {24'h000000, sw_addr};
			OFS_ADDR_USE: rd_val = {24'h000000, bus_slave_address};
			OFS_PARITY:   rd_val = {30'h0, bus_parity_select};
			OFS_PROC_MS:  rd_val = {16'h0000, proc_ms};
			OFS_DEAD_MS:  rd_val = {16'h0000, dead_ms};
			OFS_MON_MS:   rd_val = {16'h0000, bus_monitor_time};
			OFS_STATUS:   rd_val = {29'h0, status};
			OFS_MASK:     rd_val = {29'h0, mask};
			OFS_RESTART:  rd_val = 32'h0000_0000;
			OFS_DIVISOR:  rd_val = {8'h00, baud_divisor};
			default: begin
				if (s_axi_araddr[7:5] == 3'h2 && s_axi_araddr[1:0] == 2'h0) begin
					rd_val = 32'(stat[s_axi_araddr[4:2]]);
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : mbc_port_cfg
`default_nettype wire
